// ==== motor_host.sv ====
/*
 * host end: apb slave registers that drive enable, reset, source pin,
 * reference clock and config writes toward the sequencer.
 * assumes apb master on pclk; the link modport is joined by the bench.
 */
module motor_host
   import seq_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   motor_link_if.host link
);
   import seq_pkg::*;

   logic [31:0] ctrl_reg, ctrl_next;
   logic [15:0] div_reg, div_next;
   logic ref_reg, ref_next;
   logic we_next, burn_next;
   logic [3:0] addr_next;
   logic [15:0] wdata_next;
   logic [31:0] rd_next;
   logic err_next;
   logic acc, wr;

   assign acc = psel && penable;
   assign wr = acc && pwrite;

   // ***************************************
   // apb decode and pin drive
   // ***************************************
   always_comb
   begin
      ctrl_next = ctrl_reg;
      we_next = 1'b0;
      burn_next = 1'b0;
      addr_next = link.cfg_addr;
      wdata_next = link.cfg_wdata;
      rd_next = 32'h0000_0000;
      err_next = 1'b0;
      if (acc)
      begin
         unique case (paddr)
            HOFF_CTRL:
            begin
               if (pwrite)
               begin
                  ctrl_next = pwdata;
               end
               rd_next = ctrl_reg;
            end
            HOFF_WR:
            begin
               if (pwrite)
               begin
                  we_next = 1'b1;
                  addr_next = pwdata[19:16];
                  wdata_next = pwdata[15:0];
               end
               else
               begin
                  addr_next = pwdata[19:16];
               end
            end
            HOFF_RD: rd_next = {16'h0000, link.cfg_rdata};
            HOFF_STAT: rd_next = {29'h0, link.sleeping, link.running,
               link.speed_feedback_pulse_out};
            default: err_next = 1'b1;
         endcase
         if (wr && paddr == HOFF_CTRL)
         begin
            burn_next = pwdata[HC_BURN];
         end
      end
      div_next = div_reg + 16'h0001;
      ref_next = ref_reg;
      if (!ctrl_reg[HC_REFEN])
      begin
         div_next = 16'h0000;
         ref_next = 1'b0;
      end
      else if (div_reg >= ctrl_reg[HC_REFDIV_LSB +: HC_REFDIV_W])
      begin
         div_next = 16'h0000;
         ref_next = ~ref_reg;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ctrl_reg <= 32'h0000_0000;
         div_reg <= 16'h0000;
         ref_reg <= 1'b0;
         prdata <= 32'h0000_0000;
         pready <= 1'b0;
         pslverr <= 1'b0;
         link.enable_pin <= 1'b0;
         link.reset_pin <= 1'b0;
         link.config_source_select <= 1'b0;
         link.speed_reference_clock <= 1'b0;
         link.cfg_we <= 1'b0;
         link.cfg_addr <= 4'h0;
         link.cfg_wdata <= 16'h0000;
         link.otp_burn <= 1'b0;
      end
      else
      begin
         ctrl_reg <= ctrl_next;
         div_reg <= div_next;
         ref_reg <= ref_next;
         // one wait state: pready pulses in the second access cycle
         pready <= acc && !pready;
         prdata <= rd_next;
         pslverr <= err_next;
         // enable follows the ctrl word with no minimum low time; tie mode mirrors reset
         link.enable_pin <= ctrl_next[HC_TIE] ? ctrl_next[HC_RST] : ctrl_next[HC_EN];
         link.reset_pin <= ctrl_next[HC_RST];
         link.config_source_select <= ctrl_next[HC_SRC];
         link.speed_reference_clock <= ref_next;
         link.cfg_we <= we_next && !pready;
         link.cfg_addr <= addr_next;
         link.cfg_wdata <= wdata_next;
         link.otp_burn <= burn_next && !pready;
      end
   end
endmodule

// ==== motor_link_asserts.sv ====
/*
 * assertion checker for the host to sequencer link pins.
 * assumes one pclk domain; polarity changes only by word 0 writes.
 */
module motor_link_asserts
   import seq_pkg::*;
#(
   parameter int unsigned STILL_CYCLES = STILL_CYC
)
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic enable_pin,
   input wire logic reset_pin,
   input wire logic cfg_we,
   input wire logic [3:0] cfg_addr,
   input wire logic [15:0] cfg_wdata,
   input wire logic speed_feedback_pulse_out,
   input wire logic running,
   input wire logic sleeping
);
   // slack for register stages between device counters and the pins
   localparam int unsigned SPAN_MIN = STILL_CYCLES - 4;
   logic pol_reg, pol_next, fb_reg, run_reg, seen_reg, seen_next;
   logic [15:0] quiet_reg, quiet_next, inact_reg, inact_next, off_reg, off_next;
   // ***********************************
   // helper counters
   // ***********************************
   // saturating, so a long sleep never wraps them
   always_comb
   begin
      pol_next = pol_reg;
      if (cfg_we && cfg_addr == CFG0_ADDR)
         pol_next = cfg_wdata[ENABLE_POLARITY_BIT];
      quiet_next = quiet_reg + {15'h0, quiet_reg != 16'hFFFF};
      if (speed_feedback_pulse_out != fb_reg)
         quiet_next = 16'h0000;
      inact_next = 16'h0000;
      if (enable_pin == pol_reg)
         inact_next = inact_reg + {15'h0, inact_reg != 16'hFFFF};
      off_next = running ? 16'h0000 : off_reg + {15'h0, off_reg != 16'hFFFF};
      seen_next = seen_reg | (run_reg & ~running);
   end
   // registers of the helpers
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pol_reg <= 1'b0;
         fb_reg <= 1'b0;
         run_reg <= 1'b0;
         seen_reg <= 1'b0;
         quiet_reg <= 16'h0000;
         inact_reg <= 16'h0000;
         off_reg <= 16'h0000;
      end
      else
      begin
         pol_reg <= pol_next;
         fb_reg <= speed_feedback_pulse_out;
         run_reg <= running;
         seen_reg <= seen_next;
         quiet_reg <= quiet_next;
         inact_reg <= inact_next;
         off_reg <= off_next;
      end
   end
   // ***********************************
   // properties
   // ***********************************
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   property p_excl;
      !(running && sleeping);
   endproperty
   property p_quiet;
      $rose(sleeping) |-> quiet_reg >= SPAN_MIN;
   endproperty
   property p_fb_hold;
      sleeping && $past(sleeping) |-> $stable(speed_feedback_pulse_out);
   endproperty
   property p_qual;
      inact_reg == 16'h0046 |-> !running;
   endproperty
   property p_glitch;
      inact_reg == 16'h0000 && $past(inact_reg) inside {[16'h0001:16'h0028]} && running
         && !reset_pin |=> running;
   endproperty
   property p_rst_stop;
      running && reset_pin |-> ##[1:4] !running;
   endproperty
   property p_stop_len;
      $rose(running) && seen_reg |-> off_reg >= SPAN_MIN;
   endproperty
   property p_wake;
      $fell(sleeping) |-> ##[0:8] running;
   endproperty
   a_excl: assert property (p_excl) else $error("running while asleep");
   a_quiet: assert property (p_quiet) else $error("sleep before standstill");
   a_fb_hold: assert property (p_fb_hold) else $error("feedback moved in sleep");
   a_qual: assert property (p_qual) else $error("withdrawal not taken");
   a_glitch: assert property (p_glitch) else $error("short glitch stopped");
   a_rst_stop: assert property (p_rst_stop) else $error("reset did not stop");
   a_stop_len: assert property (p_stop_len) else $error("restart too early");
   a_wake: assert property (p_wake) else $error("wake without run");
   c_sleep: cover property ($rose(sleeping));
   c_wake: cover property ($fell(sleeping));
   c_restart: cover property ($rose(running) && seen_reg);
endmodule

// ==== motor_link_if.sv ====
/*
 * pin-level link between host controller and motor sequencer.
 * assumes both ends share pclk; the bench joins them.
 */
interface motor_link_if;
   logic enable_pin;
   logic reset_pin;
   logic config_source_select;
   logic speed_reference_clock;
   logic cfg_we;
   logic [3:0] cfg_addr;
   logic [15:0] cfg_wdata;
   logic [15:0] cfg_rdata;
   logic otp_burn;
   logic speed_feedback_pulse_out;
   logic running;
   logic sleeping;
   modport device (input enable_pin, input reset_pin, input config_source_select,
      input speed_reference_clock, input cfg_we, input cfg_addr, input cfg_wdata,
      input otp_burn, output cfg_rdata, output speed_feedback_pulse_out,
      output running, output sleeping);
   modport host (output enable_pin, output reset_pin, output config_source_select,
      output speed_reference_clock, output cfg_we, output cfg_addr, output cfg_wdata,
      output otp_burn, input cfg_rdata, input speed_feedback_pulse_out,
      input running, input sleeping);
endinterface

// ==== motor_sequencer.sv ====
/*
 * device end: enable/reset/sleep sequencer with config register file,
 * otp and eeprom load, drive mode and current-limit duty shortening.
 * assumes link pins synchronous to pclk; analog comparators arrive as levels.
 */
// Functional notes
// - enable withdrawal stops motor, brake or coast
// - one second without feedback edges: power down
// - sleep keeps serial register access only
// - enable inactive 1.2 us or polarity change
// - started sequence always completes, then restarts
// - reset during power-down pends until enable
// - reset while enabled: stop, reload otp
// - motor held off while reset stays asserted
// - tied reset/enable with active-low polarity works
// - no drive before valid configuration loaded
// - source pin high loads external eeprom
// - source pin low: spi writes, optional burn
// - feedback select: 00 hall u, 10 fg
// - host supplies reference clock in closed loop
// - open-loop duty or closed-loop speed lock
// - over-limit sense shortens drive duty
// - host loads open-loop baseline table
module motor_sequencer
   import seq_pkg::*;
#(
   parameter int unsigned STILL_CYCLES = STILL_CYC
)
(
   input wire logic pclk,
   input wire logic presetn,
   motor_link_if.device link,
   input wire logic hall_u,
   input wire logic fg_in,
   input wire logic current_over_limit,
   input wire logic [15:0] eeprom_word [REG_COUNT],
   output logic drive_on,
   output logic brake_active,
   output logic [7:0] drive_duty,
   output logic five_volt_regulator,
   output logic power_switch,
   output logic core_clock_on
);
   import seq_pkg::*;

   logic [15:0] cfg_reg [REG_COUNT];
   logic [15:0] cfg_next [REG_COUNT];
   logic [15:0] otp_reg [REG_COUNT];
   logic [15:0] otp_next [REG_COUNT];
   seq_state_t state_reg, state_next;
   logic [31:0] still_reg, still_next;
   logic [7:0] qual_reg, qual_next;
   logic pend_rst_reg, pend_rst_next;
   logic valid_reg, valid_next;
   logic fb_prev_reg, ref_prev_reg;
   logic [7:0] duty_reg, duty_next;
   logic [15:0] rdata_reg;
   logic enable_polarity_prev_reg;
   logic en_act, fb_sel, fb_edge, ref_edge, enable_polarity, start_stop;

   // enable polarity: bit set means enable pin active low
   assign enable_polarity = cfg_reg[CFG0_ADDR][ENABLE_POLARITY_BIT];
   assign en_act = link.enable_pin ^ enable_polarity;
   assign fb_sel = (cfg_reg[CFG0_ADDR][FBSEL_LSB +: 2] == FBSEL_FG) ? fg_in : hall_u;
   assign fb_edge = fb_sel ^ fb_prev_reg;
   assign ref_edge = link.speed_reference_clock & ~ref_prev_reg;
   assign start_stop = (qual_reg >= 8'(EN_QUAL_CYC)) || (enable_polarity != enable_polarity_prev_reg);

   // ***************************************
   // register file, otp and sequencer next state
   // ***************************************
   always_comb
   begin
      cfg_next = cfg_reg;
      otp_next = otp_reg;
      state_next = state_reg;
      still_next = still_reg;
      pend_rst_next = pend_rst_reg;
      valid_next = valid_reg;
      qual_next = en_act ? 8'h00 : ((qual_reg < 8'(EN_QUAL_CYC)) ? qual_reg + 8'h01 : qual_reg);
      // serial writes accepted in every state but ST_LOAD and the last ST_RELOAD cycle, sleep included
      if (link.cfg_we && link.cfg_addr < 4'(REG_COUNT))
      begin
         cfg_next[link.cfg_addr] = link.cfg_wdata;
      end
      if (link.otp_burn)
      begin
         otp_next = cfg_reg;
      end
      unique case (state_reg)
         ST_LOAD:
         begin
            // eeprom when source pin high, else otp
            cfg_next = link.config_source_select ? eeprom_word : otp_reg;
            valid_next = 1'b1;
            state_next = ST_RUN;
         end
         ST_RUN:
         begin
            still_next = '0;
            if (link.reset_pin)
            begin
               state_next = ST_RELOAD;
            end
            else if (start_stop)
            begin
               state_next = ST_STOP;
            end
         end
         ST_STOP:
         begin
            // runs to the end regardless of enable
            if (link.reset_pin)
            begin
               pend_rst_next = 1'b1;
            end
            still_next = fb_edge ? '0 : still_reg + 32'h1;
            if (still_reg >= STILL_CYCLES - 1)
            begin
               state_next = ST_SLEEP;
               still_next = '0;
            end
         end
         ST_SLEEP:
         begin
            if (link.reset_pin)
            begin
               pend_rst_next = 1'b1;
            end
            if (en_act)
            begin
               pend_rst_next = 1'b0;
               state_next = (pend_rst_reg || link.reset_pin) ? ST_LOAD : ST_RUN;
            end
         end
         ST_RELOAD:
         begin
            still_next = fb_edge ? '0 : still_reg + 32'h1;
            if (still_reg >= STILL_CYCLES - 1)
            begin
               cfg_next = otp_reg;
               still_next = '0;
               state_next = ST_HOLD;
            end
         end
         ST_HOLD:
         begin
            // stay off while reset held; tied pins release here
            if (!link.reset_pin)
            begin
               state_next = ST_RUN;
            end
         end
         default: state_next = ST_LOAD;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         for (int i = 0; i < REG_COUNT; i++)
         begin
            cfg_reg[i] <= 16'h0000;
            otp_reg[i] <= 16'h0000;
         end
         state_reg <= ST_LOAD;
         still_reg <= '0;
         qual_reg <= 8'h00;
         pend_rst_reg <= 1'b0;
         valid_reg <= 1'b0;
      end
      else
      begin
         cfg_reg <= cfg_next;
         otp_reg <= otp_next;
         state_reg <= state_next;
         still_reg <= still_next;
         qual_reg <= qual_next;
         pend_rst_reg <= pend_rst_next;
         valid_reg <= valid_next;
      end
   end

   // ***************************************
   // drive duty: open loop, closed loop, current limit
   // ***************************************
   always_comb
   begin
      duty_next = duty_reg;
      if (!cfg_reg[CFG0_ADDR][CLOSED_BIT])
      begin
         duty_next = cfg_reg[DUTY_ADDR][7:0];
      end
      else if (ref_edge && !fb_edge && duty_reg != 8'hFF)
      begin
         duty_next = duty_reg + 8'h01;
      end
      else if (fb_edge && !ref_edge && duty_reg != 8'h00)
      begin
         duty_next = duty_reg - 8'h01;
      end
      if (current_over_limit)
      begin
         duty_next = {1'b0, duty_reg[7:1]};
      end
   end

   // edge history, duty and pin outputs
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         fb_prev_reg <= 1'b0;
         ref_prev_reg <= 1'b0;
         enable_polarity_prev_reg <= 1'b0;
         duty_reg <= 8'h00;
         rdata_reg <= 16'h0000;
         drive_on <= 1'b0;
         brake_active <= 1'b0;
         drive_duty <= 8'h00;
         five_volt_regulator <= 1'b0;
         power_switch <= 1'b0;
         core_clock_on <= 1'b0;
         link.cfg_rdata <= 16'h0000;
         link.speed_feedback_pulse_out <= 1'b0;
         link.running <= 1'b0;
         link.sleeping <= 1'b0;
      end
      else
      begin
         fb_prev_reg <= fb_sel;
         ref_prev_reg <= link.speed_reference_clock;
         enable_polarity_prev_reg <= enable_polarity;
         duty_reg <= duty_next;
         rdata_reg <= cfg_reg[link.cfg_addr < 4'(REG_COUNT) ? link.cfg_addr : 4'h0];
         // drive only with valid config in run
         drive_on <= valid_reg && state_next == ST_RUN;
         brake_active <= (state_next == ST_STOP || state_next == ST_RELOAD)
            && cfg_reg[CFG0_ADDR][BRAKE_BIT];
         drive_duty <= (state_next == ST_RUN) ? duty_next : 8'h00;
         // supplies and clocks off in sleep
         five_volt_regulator <= state_next != ST_SLEEP;
         power_switch <= state_next != ST_SLEEP;
         core_clock_on <= state_next != ST_SLEEP;
         link.cfg_rdata <= rdata_reg;
         // feedback output frozen while clocks are stopped
         link.speed_feedback_pulse_out <= (state_next == ST_SLEEP) ?
            link.speed_feedback_pulse_out : fb_sel;
         link.running <= state_next == ST_RUN;
         link.sleeping <= state_next == ST_SLEEP;
      end
   end
endmodule

// ==== seq_pkg.sv ====
/*
 * shared constants for the motor enable/reset/sleep sequencer and its host end.
 * assumes a single 50 MHz clock (pclk) and an active-low async reset (presetn).
 */
package seq_pkg;
   // ***************************************
   // timing
   // ***************************************
   localparam int unsigned CLK_HZ = 50000000;
   localparam int unsigned CLK_PERIOD_NS = 20;
   localparam int unsigned EN_QUAL_NS = 1200;
   localparam int unsigned EN_QUAL_CYC = (EN_QUAL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned STILL_MS = 1000;
   localparam int unsigned STILL_CYC = (CLK_HZ / 1000) * STILL_MS;
   localparam int unsigned REG_COUNT = 12;
   // ***************************************
   // speed feedback select codes
   // ***************************************
   localparam logic [1:0] FBSEL_HALL_U = 2'h0;
   localparam logic [1:0] FBSEL_FG = 2'h2;
   // ***************************************
   // config register file (16-bit words, address 0x00..0x0B)
   // ***************************************
   localparam logic [3:0] CFG0_ADDR = 4'h0;
   localparam int unsigned BRAKE_BIT = 0;
   localparam int unsigned ENABLE_POLARITY_BIT = 1;
   localparam int unsigned CLOSED_BIT = 2;
   localparam int unsigned FBSEL_LSB = 4;
   localparam logic [3:0] DUTY_ADDR = 4'h2;
   // open-loop baseline table
   localparam logic [15:0] BASE_VAL [REG_COUNT] = '{16'h0911, 16'h0000, 16'h04FF, 16'h6800,
      16'h40D2, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'hF000, 16'h0000};
   // ***************************************
   // host APB register map
   // ***************************************
   localparam logic [7:0] HOFF_CTRL = 8'h00;
   localparam logic [7:0] HOFF_WR = 8'h04;
   localparam logic [7:0] HOFF_RD = 8'h08;
   localparam logic [7:0] HOFF_STAT = 8'h0C;
   localparam int unsigned HC_EN = 0;
   localparam int unsigned HC_RST = 1;
   localparam int unsigned HC_SRC = 2;
   localparam int unsigned HC_REFEN = 3;
   localparam int unsigned HC_BURN = 4;
   localparam int unsigned HC_TIE = 5;
   localparam int unsigned HC_REFDIV_LSB = 8;
   localparam int unsigned HC_REFDIV_W = 16;
   typedef enum logic [2:0] {ST_LOAD, ST_RUN, ST_STOP, ST_SLEEP, ST_RELOAD, ST_HOLD} seq_state_t;
endpackage

// ==== tb_top.sv ====
/*
 * testbench: host and sequencer joined by the link, driven over apb.
 * assumes seq_pkg constants and a shortened standstill count.
 */
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import seq_pkg::*;
   localparam int unsigned STILL = 200;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h00000000;
   logic [31:0] prdata, rd;
   logic pready, pslverr, er, drive_on, brake_active, vreg, psw, cclk;
   logic hall_u = 1'b0;
   logic fg_in = 1'b0;
   logic ovl = 1'b0;
   logic [15:0] eew [REG_COUNT];
   logic [7:0] duty;
   int fails = 0;
   int tests_run = 0;
   int n;
   always #10 pclk = ~pclk;
   // ***********************************
   // design and checker
   // ***********************************
   motor_link_if motor_link_if_inst ();
   motor_host motor_host_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .link(motor_link_if_inst));
   motor_sequencer #(.STILL_CYCLES(STILL)) motor_sequencer_inst (.pclk(pclk),
      .presetn(presetn), .link(motor_link_if_inst), .hall_u(hall_u), .fg_in(fg_in),
      .current_over_limit(ovl), .eeprom_word(eew), .drive_on(drive_on),
      .brake_active(brake_active), .drive_duty(duty), .five_volt_regulator(vreg),
      .power_switch(psw), .core_clock_on(cclk));
   motor_link_asserts #(.STILL_CYCLES(STILL)) motor_link_asserts_inst (.pclk(pclk),
      .presetn(presetn), .enable_pin(motor_link_if_inst.enable_pin),
      .reset_pin(motor_link_if_inst.reset_pin), .cfg_we(motor_link_if_inst.cfg_we),
      .cfg_addr(motor_link_if_inst.cfg_addr), .cfg_wdata(motor_link_if_inst.cfg_wdata),
      .speed_feedback_pulse_out(motor_link_if_inst.speed_feedback_pulse_out),
      .running(motor_link_if_inst.running), .sleeping(motor_link_if_inst.sleeping));
   wire run_w = motor_link_if_inst.running;
   wire slp_w = motor_link_if_inst.sleeping;
   // ***********************************
   // tasks
   // ***********************************
   task automatic test_done();
      $display("checks %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      tests_run++;
      if (g !== e)
      begin
         fails++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask
   // one apb transfer; an idle cycle after keeps psel from two writes in one step
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do
      begin
         @(posedge pclk);
         k++;
      end
      while (pready !== 1'b1 && k < 50);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (k >= 50)
      begin
         fails++;
         test_done();
      end
      @(posedge pclk);
   endtask
   task automatic cfg(input logic [3:0] a, input logic [15:0] d);
      apb(1'b1, HOFF_WR, {12'h000, a, d});
   endtask
   // bounded wait for running (s=0) or sleeping (s=1) to reach v
   task automatic wt(input logic s, input logic v);
      n = 0;
      while ((s ? slp_w : run_w) !== v)
      begin
         @(posedge pclk);
         n++;
         if (n > 3000)
         begin
            fails++;
            test_done();
         end
      end
   endtask
   // ***********************************
   // main sequence
   // ***********************************
   initial
   begin
      foreach (eew[i])
         eew[i] = BASE_VAL[i];
      eew[2] = 16'h0077;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      for (int i = 0; i < REG_COUNT; i++)
      begin
         cfg(i[3:0], BASE_VAL[i]);
         apb(1'b0, HOFF_RD, 32'h00000000);
         chk("cfg word", {16'h0000, BASE_VAL[i]}, rd);
      end
      apb(1'b0, 8'h10, 32'h00000000);
      chk("unmapped", 32'h00000001, {31'h0, er});
      $display("end baseline");
      apb(1'b1, HOFF_CTRL, 32'h00000001);
      wt(1'b0, 1'b1);
      apb(1'b1, HOFF_CTRL, 32'h00000011);
      chk("on outputs", 32'h00000FFF, {20'h0, duty, drive_on, vreg, psw, cclk});
      ovl <= 1'b1;
      repeat (4) @(posedge pclk);
      chk("limited", 32'h00000001, {31'h0, duty <= 8'h7F});
      ovl <= 1'b0;
      repeat (4) @(posedge pclk);
      chk("unlimited", 32'h000000FF, {24'h0, duty});
      for (int k = 0; k < 2; k++)
      begin
         cfg(CFG0_ADDR, k[0] ? 16'h0921 : 16'h0901);
         hall_u <= ~k[0];
         fg_in <= k[0];
         repeat (4) @(posedge pclk);
         apb(1'b0, HOFF_STAT, 32'h00000000);
         chk("feedback", 32'h00000001, {31'h0, rd[0]});
      end
      hall_u <= 1'b0;
      apb(1'b1, HOFF_CTRL, 32'h00000000);
      apb(1'b1, HOFF_CTRL, 32'h00000001);
      chk("glitch run", 32'h00000001, {31'h0, run_w});
      $display("end run");
      apb(1'b1, HOFF_CTRL, 32'h00000000);
      wt(1'b0, 1'b0);
      chk("brake", 32'h00000001, {31'h0, brake_active});
      repeat (20)
      begin
         fg_in <= ~fg_in;
         @(posedge pclk);
      end
      wt(1'b1, 1'b1);
      chk("quiet span", 32'h00000001, {31'h0, n >= STILL});
      chk("sleep power", 32'h00000000, {29'h0, vreg, psw, cclk});
      fg_in <= ~fg_in;
      cfg(4'h3, 16'h1234);
      apb(1'b0, HOFF_RD, 32'h00000000);
      chk("sleep cfg", 32'h00001234, rd);
      apb(1'b1, HOFF_CTRL, 32'h00000001);
      wt(1'b0, 1'b1);
      chk("wake power", 32'h00000007, {29'h0, vreg, psw, cclk});
      $display("end sleep");
      cfg(CFG0_ADDR, 16'h0920);
      apb(1'b1, HOFF_CTRL, 32'h00000000);
      wt(1'b0, 1'b0);
      chk("qual span", 32'h00000001, {31'h0, n >= EN_QUAL_CYC - 4});
      apb(1'b1, HOFF_CTRL, 32'h00000001);
      chk("coast stop", 32'h00000000, {30'h0, run_w, brake_active});
      wt(1'b0, 1'b1);
      chk("stop span", 32'h00000001, {31'h0, n >= STILL - 12});
      $display("end restart");
      cfg(4'h2, 16'h0011);
      repeat (4) @(posedge pclk);
      chk("duty", 32'h00000011, {24'h0, duty});
      // closed loop: reference edges with a still feedback raise the duty
      cfg(CFG0_ADDR, 16'h0924);
      apb(1'b1, HOFF_CTRL, 32'h00000409);
      repeat (40) @(posedge pclk);
      chk("closed loop", 32'h00000001, {31'h0, duty > 8'h11});
      apb(1'b1, HOFF_CTRL, 32'h00000003);
      wt(1'b0, 1'b0);
      repeat (STILL + 100) @(posedge pclk);
      chk("reset hold", 32'h00000000, {31'h0, run_w});
      apb(1'b1, HOFF_CTRL, 32'h00000001);
      wt(1'b0, 1'b1);
      chk("otp duty", 32'h000000FF, {24'h0, duty});
      $display("end reload");
      apb(1'b1, HOFF_CTRL, 32'h00000000);
      wt(1'b1, 1'b1);
      apb(1'b1, HOFF_CTRL, 32'h00000006);
      chk("pending", 32'h00000001, {30'h0, run_w, slp_w});
      apb(1'b1, HOFF_CTRL, 32'h00000005);
      wt(1'b0, 1'b1);
      // first run cycle still shows the duty of the old word set
      @(posedge pclk);
      chk("eeprom duty", 32'h00000077, {24'h0, duty});
      $display("end pending reset");
      test_done();
   end
endmodule
